// *** verilog/tile_status_pkg.sv ***
// Constants and carrier types for the tile processor-status register bank
package tile_status_pkg;
    // Resource identifier tag carried in the low byte of a status access
    localparam logic [7:0] PS_RES_TAG = 8'h0B;
    localparam int PS_NUM_LSB = 8;
    // Register numbers
    localparam logic [7:0] REG_TILE_FEATURE_CONTROL = 8'h02;
    localparam logic [7:0] REG_TILE_BOOT_STATUS = 8'h03;
    localparam logic [7:0] REG_SECURITY_CONFIGURATION = 8'h05;
    localparam logic [7:0] REG_RING_OSC_CONTROL = 8'h06;
    localparam logic [7:0] REG_RING_OSC_COUNT_TILE_CELL = 8'h07;
    localparam logic [7:0] REG_RING_OSC_COUNT_TILE_WIRE = 8'h08;
    localparam logic [7:0] REG_RING_OSC_COUNT_PERIPH_CELL = 8'h09;
    localparam logic [7:0] REG_RING_OSC_COUNT_PERIPH_WIRE = 8'h0A;
    localparam logic [7:0] REG_MEMORY_SIZE = 8'h0C;
    // Tile feature control fields
    localparam int CTL_TX_DELAY_LSB = 18;
    localparam int CTL_TX_DELAY_MSB = 25;
    localparam int CTL_TX_DIV_LSB = 9;
    localparam int CTL_TX_DIV_MSB = 17;
    localparam int CTL_RGMII_EN_BIT = 8;
    localparam int CTL_DIV_DYNAMIC_BIT = 5;
    localparam int CTL_DIV_ENABLE_BIT = 4;
    localparam int CTL_UTMI_SEL_BIT = 2;
    localparam int CTL_ULPI_HW_BIT = 1;
    localparam logic [7:0] CTL_TX_DELAY_RST = 8'h00;
    localparam logic [8:0] CTL_TX_DIV_RST = 9'h000;
    localparam logic CTL_RGMII_EN_RST = 1'b0;
    localparam logic CTL_DIV_DYNAMIC_RST = 1'b0;
    localparam logic CTL_DIV_ENABLE_RST = 1'b0;
    localparam logic CTL_UTMI_SEL_RST = 1'b0;
    localparam logic CTL_ULPI_HW_RST = 1'b0;
    // Boot status fields
    localparam int BOOT_PROC_LSB = 16;
    localparam int BOOT_OVERRIDE_BIT = 8;
    localparam int BOOT_CORE1_OFF_BIT = 5;
    localparam int BOOT_SKIP_POLL_BIT = 4;
    localparam int BOOT_FROM_RAM_BIT = 3;
    localparam int BOOT_FROM_JTAG_BIT = 2;
    localparam int BOOT_PLL_MODE_LSB = 0;
    // Security configuration fields
    localparam int SEC_WRITE_LOCK_BIT = 31;
    localparam int SEC_DEBUG_BLOCK_BIT = 14;
    localparam int SEC_OTP_LOCK_ALL_BIT = 12;
    localparam int SEC_OTP_SECTOR_LSB = 8;
    localparam int SEC_OTP_REDUND_BIT = 7;
    localparam int SEC_BOOT_OTP_BIT = 5;
    localparam int SEC_JTAG_CFG_DENY_BIT = 4;
    localparam int SEC_JTAG_TAP_BLOCK_BIT = 0;
    localparam logic [31:0] SEC_WRITE_MASK = 32'h8000_5FB1;
    localparam logic [31:0] SEC_RST = 32'h0000_0000;
    // Ring oscillator control
    localparam int ROSC_CORE_EN_BIT = 1;
    localparam int ROSC_PERIPH_EN_BIT = 0;
    localparam logic [1:0] ROSC_CTL_RST = 2'h0;
    localparam int ROSC_COUNT = 4;
    localparam int ROSC_WIDTH = 16;
    // Memory size word keeps its two low bits clear
    localparam logic [31:0] MEM_SIZE_MASK = 32'hFFFF_FFFC;

    typedef struct packed {
        logic [7:0] procNum;
        logic modeOverride;
        logic core1Off;
        logic skipOtpPoll;
        logic bootRam;
        logic bootJtag;
        logic [1:0] pllMode;
    } boot_info_t;

    typedef struct packed {
        logic [7:0] txDelay;
        logic [8:0] txDiv;
        logic rgmiiEn;
        logic divDynamic;
        logic divEnable;
        logic utmiSel;
        logic ulpiHw;
    } tile_ctl_t;

    typedef struct packed {
        logic writeLock;
        logic debugBlock;
        logic otpLockAll;
        logic [3:0] otpSectorLock;
        logic otpRedundancy;
        logic bootFromOtp;
        logic jtagCfgDeny;
        logic jtagTapBlock;
    } sec_view_t;
endpackage : tile_status_pkg

// *** verilog/tile_status_control_regs.sv ***
// Processor-status register bank of one tile with clocking and oscillators
`timescale 1ns/1ps
`default_nettype none

module tile_status_control_regs #(
    parameter logic [31:0] MEM_BYTES = 32'h0002_0000,
    parameter int DIV_WIDTH = 9,
    parameter int DELAY_WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Processor-status access port
    input wire logic [31:0] psResId,
    input wire logic psWrEn,
    input wire logic [31:0] psWrData,
    input wire logic psRdEn,
    output var logic [31:0] psRdData,
    // Boot straps and OTP copy of security settings
    input wire tile_status_pkg::boot_info_t bootPins,
    input wire logic otpSecLoad,
    input wire logic [31:0] otpSecWord,
    // Thread state for the dynamic divider
    input wire logic allThreadsPaused,
    // Asynchronous clock sources seen as sampled waves
    input wire logic pllOut,
    input wire logic [3:0] roscWave,
    // Transmit clocking
    output var logic txClk,
    output var logic txDataLaunch,
    output var logic rgmiiPortsEn,
    // Low-power divider and USB transceiver selection
    output var logic clkDivActive,
    output var logic utmiSelect,
    output var logic ulpiHwEnable,
    // Security view
    output var tile_status_pkg::sec_view_t secView,
    // Oscillator enables
    output var logic roscCoreEn,
    output var logic roscPeriphEn
);

    typedef struct packed {
        tile_status_pkg::tile_ctl_t ctl;
        logic [31:0] sec;
        logic [1:0] roscCtl;
        logic [3:0][15:0] roscCnt;
        // Set by every reset, so only the first reset clears the counters
        logic roscKept;
        logic pllS1;
        logic pllS2;
        logic pllS3;
        logic [3:0] roscS1;
        logic [3:0] roscS2;
        logic [3:0] roscS3;
        logic [1:0] enS1;
        logic [1:0] enS2;
        tile_status_pkg::boot_info_t bootS1;
        tile_status_pkg::boot_info_t bootS2;
        logic [DIV_WIDTH-1:0] txCnt;
        logic txClk;
        logic [DELAY_WIDTH-1:0] delayCnt;
        logic delayRun;
        logic txLaunch;
        logic divActive;
        logic [31:0] rdData;
    } state_t;

    localparam state_t RST_STATE = '{
        ctl: '{
            txDelay: tile_status_pkg::CTL_TX_DELAY_RST,
            txDiv: tile_status_pkg::CTL_TX_DIV_RST,
            rgmiiEn: tile_status_pkg::CTL_RGMII_EN_RST,
            divDynamic: tile_status_pkg::CTL_DIV_DYNAMIC_RST,
            divEnable: tile_status_pkg::CTL_DIV_ENABLE_RST,
            utmiSel: tile_status_pkg::CTL_UTMI_SEL_RST,
            ulpiHw: tile_status_pkg::CTL_ULPI_HW_RST
        },
        sec: tile_status_pkg::SEC_RST,
        roscCtl: tile_status_pkg::ROSC_CTL_RST,
        roscKept: 1'b1,
        default: '0
    };

    state_t st_q;
    state_t st_d;

    logic psHit;
    logic [7:0] psNum;
    logic pllEdge;
    logic [3:0] roscEdge;
    logic [3:0] roscRun;
    logic [31:0] ctlWord;
    logic [31:0] bootWord;

    // Resource id decode: tag in the low byte, number above it
    assign psHit = (psResId[7:0] == tile_status_pkg::PS_RES_TAG);
    assign psNum = psResId[tile_status_pkg::PS_NUM_LSB +: 8];

    // Edges are taken from the second and third stages only
    assign pllEdge = st_q.pllS2 & ~st_q.pllS3;
    assign roscEdge = st_q.roscS2 & ~st_q.roscS3;

    // Counters for tile oscillators follow the core enable, the rest the
    // peripheral enable, both as seen after synchronisation
    assign roscRun = {
        {2{st_q.enS2[tile_status_pkg::ROSC_PERIPH_EN_BIT]}},
        {2{st_q.enS2[tile_status_pkg::ROSC_CORE_EN_BIT]}}
    };

    always_comb
    begin
        ctlWord = 32'h0000_0000;
        ctlWord[tile_status_pkg::CTL_TX_DELAY_MSB:
            tile_status_pkg::CTL_TX_DELAY_LSB] = st_q.ctl.txDelay;
        ctlWord[tile_status_pkg::CTL_TX_DIV_MSB:
            tile_status_pkg::CTL_TX_DIV_LSB] = st_q.ctl.txDiv;
        ctlWord[tile_status_pkg::CTL_RGMII_EN_BIT] = st_q.ctl.rgmiiEn;
        ctlWord[tile_status_pkg::CTL_DIV_DYNAMIC_BIT] = st_q.ctl.divDynamic;
        ctlWord[tile_status_pkg::CTL_DIV_ENABLE_BIT] = st_q.ctl.divEnable;
        ctlWord[tile_status_pkg::CTL_UTMI_SEL_BIT] = st_q.ctl.utmiSel;
        ctlWord[tile_status_pkg::CTL_ULPI_HW_BIT] = st_q.ctl.ulpiHw;
    end

    always_comb
    begin
        bootWord = 32'h0000_0000;
        bootWord[tile_status_pkg::BOOT_PROC_LSB +: 8] = st_q.bootS2.procNum;
        bootWord[tile_status_pkg::BOOT_OVERRIDE_BIT] =
            st_q.bootS2.modeOverride;
        bootWord[tile_status_pkg::BOOT_CORE1_OFF_BIT] = st_q.bootS2.core1Off;
        bootWord[tile_status_pkg::BOOT_SKIP_POLL_BIT] = st_q.bootS2.skipOtpPoll;
        bootWord[tile_status_pkg::BOOT_FROM_RAM_BIT] = st_q.bootS2.bootRam;
        bootWord[tile_status_pkg::BOOT_FROM_JTAG_BIT] = st_q.bootS2.bootJtag;
        bootWord[tile_status_pkg::BOOT_PLL_MODE_LSB +: 2] = st_q.bootS2.pllMode;
    end

    always_comb
    begin
        st_d = st_q;

        // Two-flop synchronisers for every pin from another clock
        st_d.pllS1 = pllOut;
        st_d.pllS2 = st_q.pllS1;
        st_d.pllS3 = st_q.pllS2;
        st_d.roscS1 = roscWave;
        st_d.roscS2 = st_q.roscS1;
        st_d.roscS3 = st_q.roscS2;
        st_d.enS1 = st_q.roscCtl;
        st_d.enS2 = st_q.enS1;
        st_d.bootS1 = bootPins;
        st_d.bootS2 = st_q.bootS1;

        // Oscillator counters advance on each sampled rising wave edge while their synchronised enable is set
        for (int i = 0; i < tile_status_pkg::ROSC_COUNT; i++)
        begin
            if (roscRun[i] && roscEdge[i])
            begin
                st_d.roscCnt[i] = st_q.roscCnt[i] + 16'h0001;
            end
        end

        // Transmit clock divider, counting PLL output edges
        if (!st_q.ctl.rgmiiEn)
        begin
            st_d.txCnt = '0;
            st_d.txClk = 1'b0;
        end
        else if (pllEdge)
        begin
            if (st_q.txCnt == st_q.ctl.txDiv)
            begin
                st_d.txCnt = '0;
                st_d.txClk = 1'b1;
            end
            else
            begin
                st_d.txCnt = st_q.txCnt + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                if (st_q.txCnt == (st_q.ctl.txDiv >> 1))
                begin
                    st_d.txClk = 1'b0;
                end
            end
        end

        // Data launch follows each transmit clock rise by the set delay
        st_d.txLaunch = 1'b0;
        if (!st_q.ctl.rgmiiEn)
        begin
            st_d.delayRun = 1'b0;
            st_d.delayCnt = '0;
        end
        else if (st_d.txClk && !st_q.txClk)
        begin
            if (st_q.ctl.txDelay == '0)
            begin
                st_d.txLaunch = 1'b1;
                st_d.delayRun = 1'b0;
            end
            else
            begin
                st_d.delayCnt = st_q.ctl.txDelay;
                st_d.delayRun = 1'b1;
            end
        end
        else if (st_q.delayRun && pllEdge)
        begin
            st_d.delayCnt = st_q.delayCnt - {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
            if (st_q.delayCnt == {{(DELAY_WIDTH-1){1'b0}}, 1'b1})
            begin
                st_d.txLaunch = 1'b1;
                st_d.delayRun = 1'b0;
            end
        end

        // Low-power divider, static or gated by paused threads
        st_d.divActive = st_q.ctl.divEnable &&
            (!st_q.ctl.divDynamic || allThreadsPaused);

        // Register writes
        if (psWrEn && psHit)
        begin
            unique case (psNum)
                tile_status_pkg::REG_TILE_FEATURE_CONTROL:
                begin
                    st_d.ctl.txDelay = psWrData[tile_status_pkg::CTL_TX_DELAY_MSB:
                        tile_status_pkg::CTL_TX_DELAY_LSB];
                    st_d.ctl.txDiv = psWrData[tile_status_pkg::CTL_TX_DIV_MSB:
                        tile_status_pkg::CTL_TX_DIV_LSB];
                    st_d.ctl.rgmiiEn =
                        psWrData[tile_status_pkg::CTL_RGMII_EN_BIT];
                    st_d.ctl.divDynamic =
                        psWrData[tile_status_pkg::CTL_DIV_DYNAMIC_BIT];
                    st_d.ctl.divEnable =
                        psWrData[tile_status_pkg::CTL_DIV_ENABLE_BIT];
                    st_d.ctl.utmiSel =
                        psWrData[tile_status_pkg::CTL_UTMI_SEL_BIT];
                    st_d.ctl.ulpiHw =
                        psWrData[tile_status_pkg::CTL_ULPI_HW_BIT];
                end
                tile_status_pkg::REG_SECURITY_CONFIGURATION:
                begin
                    if (!st_q.sec[tile_status_pkg::SEC_WRITE_LOCK_BIT])
                    begin
                        st_d.sec = psWrData &
                            tile_status_pkg::SEC_WRITE_MASK;
                    end
                end
                tile_status_pkg::REG_RING_OSC_CONTROL:
                begin
                    st_d.roscCtl = psWrData[1:0];
                end
                default:
                begin
                end
            endcase
        end

        // The OTP copy is loaded by hardware whatever the write lock says
        if (otpSecLoad)
        begin
            st_d.sec = otpSecWord & tile_status_pkg::SEC_WRITE_MASK;
        end

        // Register reads, answered one cycle after the request
        if (psRdEn)
        begin
            if (!psHit)
            begin
                st_d.rdData = 32'h0000_0000;
            end
            else
            begin
                unique case (psNum)
                    tile_status_pkg::REG_TILE_FEATURE_CONTROL:
                        st_d.rdData = ctlWord;
                    tile_status_pkg::REG_TILE_BOOT_STATUS:
                        st_d.rdData = bootWord;
                    tile_status_pkg::REG_SECURITY_CONFIGURATION:
                        st_d.rdData = st_q.sec;
                    tile_status_pkg::REG_RING_OSC_CONTROL:
                        st_d.rdData = {30'h0000_0000, st_q.roscCtl};
                    tile_status_pkg::REG_RING_OSC_COUNT_TILE_CELL:
                        st_d.rdData = {16'h0000, st_q.roscCnt[0]};
                    tile_status_pkg::REG_RING_OSC_COUNT_TILE_WIRE:
                        st_d.rdData = {16'h0000, st_q.roscCnt[1]};
                    tile_status_pkg::REG_RING_OSC_COUNT_PERIPH_CELL:
                        st_d.rdData = {16'h0000, st_q.roscCnt[2]};
                    tile_status_pkg::REG_RING_OSC_COUNT_PERIPH_WIRE:
                        st_d.rdData = {16'h0000, st_q.roscCnt[3]};
                    tile_status_pkg::REG_MEMORY_SIZE:
                        st_d.rdData = MEM_BYTES &
                            tile_status_pkg::MEM_SIZE_MASK;
                    default:
                        st_d.rdData = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= RST_STATE;
            // Power-up counts are cleared; later resets keep them
            if (st_q.roscKept)
            begin
                st_q.roscCnt <= st_d.roscCnt;
            end
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign psRdData = st_q.rdData;
    assign txClk = st_q.txClk;
    assign txDataLaunch = st_q.txLaunch;
    assign rgmiiPortsEn = st_q.ctl.rgmiiEn;
    assign clkDivActive = st_q.divActive;
    assign utmiSelect = st_q.ctl.utmiSel;
    assign ulpiHwEnable = st_q.ctl.ulpiHw;
    assign secView.writeLock = st_q.sec[tile_status_pkg::SEC_WRITE_LOCK_BIT];
    assign secView.debugBlock =
        st_q.sec[tile_status_pkg::SEC_DEBUG_BLOCK_BIT];
    assign secView.otpLockAll = st_q.sec[tile_status_pkg::SEC_OTP_LOCK_ALL_BIT];
    assign secView.otpSectorLock =
        st_q.sec[tile_status_pkg::SEC_OTP_SECTOR_LSB +: 4];
    assign secView.otpRedundancy =
        st_q.sec[tile_status_pkg::SEC_OTP_REDUND_BIT];
    assign secView.bootFromOtp =
        st_q.sec[tile_status_pkg::SEC_BOOT_OTP_BIT];
    assign secView.jtagCfgDeny =
        st_q.sec[tile_status_pkg::SEC_JTAG_CFG_DENY_BIT];
    assign secView.jtagTapBlock =
        st_q.sec[tile_status_pkg::SEC_JTAG_TAP_BLOCK_BIT];
    assign roscCoreEn = st_q.roscCtl[tile_status_pkg::ROSC_CORE_EN_BIT];
    assign roscPeriphEn =
        st_q.roscCtl[tile_status_pkg::ROSC_PERIPH_EN_BIT];

endmodule : tile_status_control_regs

`default_nettype wire

// *** verification/tile_status_control_regs_checker.sv ***
// Concurrent property checker for the tile status register bank
`timescale 1ns/1ps
`default_nettype none
module tile_status_control_regs_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Processor-status access port
    input wire logic [31:0] psResId,
    input wire logic psWrEn,
    input wire logic [31:0] psWrData,
    input wire logic psRdEn,
    input wire logic [31:0] psRdData,
    // Security load and thread state
    input wire logic otpSecLoad,
    input wire logic [31:0] otpSecWord,
    input wire logic allThreadsPaused,
    // Observed outputs
    input wire logic txClk,
    input wire logic rgmiiPortsEn,
    input wire logic clkDivActive,
    input wire logic utmiSelect,
    input wire logic ulpiHwEnable,
    input wire tile_status_pkg::sec_view_t secView,
    input wire logic roscCoreEn,
    input wire logic roscPeriphEn
);
    logic tagOk;
    logic ctlWr;
    logic secWr;
    logic oscWr;
    assign tagOk = psResId[7:0] == tile_status_pkg::PS_RES_TAG;
    assign ctlWr = psWrEn && tagOk
        && psResId[15:8] == tile_status_pkg::REG_TILE_FEATURE_CONTROL;
    assign secWr = psWrEn && tagOk
        && psResId[15:8] == tile_status_pkg::REG_SECURITY_CONFIGURATION;
    assign oscWr = psWrEn && tagOk
        && psResId[15:8] == tile_status_pkg::REG_RING_OSC_CONTROL;

    function automatic logic [10:0] secBits(input logic [31:0] w);
        return {w[31], w[14], w[12], w[11:8], w[7], w[5], w[4], w[0]};
    endfunction : secBits

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_ctlQuiet;
        !ctlWr;
    endsequence
    sequence s_dynBusy;
        !ctlWr && !allThreadsPaused;
    endsequence

    property p_ctlOut;
        ctlWr |=> rgmiiPortsEn == $past(psWrData[8])
            && utmiSelect == $past(psWrData[2])
            && ulpiHwEnable == $past(psWrData[1]);
    endproperty
    a_ctlOut: assert property (p_ctlOut)
        else $error("control outputs do not follow the written word");
    property p_divOff;
        ctlWr && !psWrData[4] ##1 s_ctlQuiet |=> !clkDivActive;
    endproperty
    a_divOff: assert property (p_divOff)
        else $error("divider active while disabled");
    property p_divStatic;
        ctlWr && psWrData[5:4] == 2'b01 ##1 s_ctlQuiet |=> clkDivActive;
    endproperty
    a_divStatic: assert property (p_divStatic)
        else $error("static divider not active");
    property p_divDyn;
        ctlWr && psWrData[5:4] == 2'b11 ##1 s_dynBusy |=> !clkDivActive;
    endproperty
    a_divDyn: assert property (p_divDyn)
        else $error("dynamic divider active while threads run");
    property p_secLock;
        secWr && secView.writeLock && !otpSecLoad |=> $stable(secView);
    endproperty
    a_secLock: assert property (p_secLock)
        else $error("locked security word changed by a write");
    property p_secWr;
        secWr && !secView.writeLock && !otpSecLoad
            |=> secView == secBits($past(psWrData));
    endproperty
    a_secWr: assert property (p_secWr)
        else $error("security view does not match the written word");
    property p_otpLoad;
        otpSecLoad |=> secView == secBits($past(otpSecWord));
    endproperty
    a_otpLoad: assert property (p_otpLoad)
        else $error("security view does not match the loaded word");
    property p_oscEn;
        oscWr |=> {roscCoreEn, roscPeriphEn} == $past(psWrData[1:0]);
    endproperty
    a_oscEn: assert property (p_oscEn)
        else $error("oscillator enables do not follow the write");
    property p_txIdle;
        !rgmiiPortsEn [*2] |-> !txClk;
    endproperty
    a_txIdle: assert property (p_txIdle)
        else $error("transmit clock high while ports disabled");
    property p_badTag;
        psRdEn && !tagOk |=> psRdData == 32'h0000_0000;
    endproperty
    a_badTag: assert property (p_badTag)
        else $error("read with a foreign tag returned data");
endmodule : tile_status_control_regs_checker

bind tile_status_control_regs tile_status_control_regs_checker chk (
    .mclk(mclk), .sys_rst(sys_rst), .psResId(psResId), .psWrEn(psWrEn),
    .psWrData(psWrData), .psRdEn(psRdEn), .psRdData(psRdData),
    .otpSecLoad(otpSecLoad), .otpSecWord(otpSecWord),
    .allThreadsPaused(allThreadsPaused), .txClk(txClk),
    .rgmiiPortsEn(rgmiiPortsEn), .clkDivActive(clkDivActive),
    .utmiSelect(utmiSelect), .ulpiHwEnable(ulpiHwEnable),
    .secView(secView), .roscCoreEn(roscCoreEn), .roscPeriphEn(roscPeriphEn)
);
`default_nettype wire

// *** verification/tb_tile_status_control_regs.sv ***
// Self-checking testbench for the tile status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_tile_status_control_regs;
    localparam logic [31:0] MEM_BYTES = 32'h0001_2347;
    localparam logic [31:0] SMASK = tile_status_pkg::SEC_WRITE_MASK;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] psResId = 32'h0;
    logic psWrEn = 1'b0;
    logic [31:0] psWrData = 32'h0;
    logic psRdEn = 1'b0;
    logic [31:0] psRdData;
    tile_status_pkg::boot_info_t bootPins = '0;
    logic otpSecLoad = 1'b0;
    logic [31:0] otpSecWord = 32'h0;
    logic allThreadsPaused = 1'b0;
    logic pllOut = 1'b0;
    logic [3:0] roscWave = 4'h0;
    logic txClk, txDataLaunch, rgmiiPortsEn, clkDivActive;
    logic utmiSelect, ulpiHwEnable, roscCoreEn, roscPeriphEn;
    tile_status_pkg::sec_view_t secView;
    int bad_count = 0;
    int cmp_count = 0;
    int c, m, i;
    logic [31:0] seed = 32'hECFA042E;
    logic [31:0] d, prev, e;
    logic [31:0] base [4] = '{default: 32'h0};
    logic [1:0] en;
    logic [31:0] expQ [$];
    string nameQ [$];
    string nm;
    logic rdSeen = 1'b0;

    tile_status_control_regs #(.MEM_BYTES(MEM_BYTES)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .psResId(psResId),
        .psWrEn(psWrEn), .psWrData(psWrData), .psRdEn(psRdEn),
        .psRdData(psRdData), .bootPins(bootPins), .otpSecLoad(otpSecLoad),
        .otpSecWord(otpSecWord), .allThreadsPaused(allThreadsPaused),
        .pllOut(pllOut), .roscWave(roscWave), .txClk(txClk),
        .txDataLaunch(txDataLaunch), .rgmiiPortsEn(rgmiiPortsEn),
        .clkDivActive(clkDivActive), .utmiSelect(utmiSelect),
        .ulpiHwEnable(ulpiHwEnable), .secView(secView),
        .roscCoreEn(roscCoreEn), .roscPeriphEn(roscPeriphEn)
    );

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // PLL wave with a period of four bench clocks
    always
    begin
        repeat (2) @(posedge mclk);
        #1 pllOut = ~pllOut;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string n, input logic [31:0] seen, ex);
        cmp_count++;
        if (seen !== ex)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, ex, seen);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    task automatic acc(input logic we, re, input logic [7:0] num,
                       input logic [31:0] dat, input logic [7:0] tg = 8'h0B);
        psWrEn = we;
        psRdEn = re;
        psResId = {16'h0000, num, tg};
        psWrData = dat;
        step(1);
    endtask : acc

    task automatic idle(input int k);
        psWrEn = 1'b0;
        psRdEn = 1'b0;
        step(k);
    endtask : idle

    task automatic rd(input logic [7:0] num, input logic [31:0] ex,
                      input string n, input logic [7:0] tg = 8'h0B);
        expQ.push_back(ex);
        nameQ.push_back(n);
        acc(1'b0, 1'b1, num, 32'h0, tg);
    endtask : rd

    task automatic waitTx(input logic lvl, output int k);
        k = 0;
        while (txClk !== lvl && k < 200)
        begin
            step(1);
            k++;
        end
    endtask : waitTx

    // Read results land one clock after the strobe
    always @(posedge mclk) rdSeen <= psRdEn && !sys_rst;
    always @(negedge mclk)
        if (rdSeen && nameQ.size() > 0)
        begin
            nm = nameQ.pop_front();
            e = expQ.pop_front();
            if (nm != "")
                check(nm, psRdData, e);
        end

    initial
    begin
        step(4);
        sys_rst = 1'b0;
        rd(8'h02, 32'h0, "ctlReset");
        rd(8'h06, 32'h0, "oscReset");
        rd(8'h0C, MEM_BYTES & 32'hFFFF_FFFC, "memSize");
        acc(1'b1, 1'b0, 8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, MEM_BYTES & 32'hFFFF_FFFC, "memSizeRo");
        rd(8'h04, 32'h0, "unmapped");
        prev = 32'h0;
        // Write and read in one cycle returns the old word
        repeat (8)
        begin
            d = rnd();
            allThreadsPaused = d[31];
            expQ.push_back(prev);
            nameQ.push_back("ctlOld");
            acc(1'b1, 1'b1, 8'h02, d);
            prev = d & 32'h03FF_FF36;
            rd(8'h02, prev, "ctl");
            idle(3);
        end
        acc(1'b1, 1'b0, 8'h02, ~prev, 8'h0C);
        rd(8'h02, prev, "ctlTag");
        rd(8'h02, 32'h0, "rdTag", 8'h0C);
        $display("control test done");
        d = rnd();
        bootPins = d[14:0];
        idle(4);
        e = {8'h00, d[14:7], 7'h00, d[6], 2'h0, d[5:0]};
        acc(1'b1, 1'b0, 8'h03, ~e);
        rd(8'h03, e, "boot");
        $display("boot test done");
        d = rnd() & 32'h7FFF_FFFF;
        acc(1'b1, 1'b0, 8'h05, d);
        rd(8'h05, d & SMASK, "secWr");
        acc(1'b1, 1'b0, 8'h05, d | 32'h8000_0000);
        acc(1'b1, 1'b0, 8'h05, ~d);
        rd(8'h05, (d | 32'h8000_0000) & SMASK, "secLock");
        otpSecWord = rnd();
        otpSecLoad = 1'b1;
        acc(1'b1, 1'b0, 8'h05, ~otpSecWord);
        otpSecLoad = 1'b0;
        rd(8'h05, otpSecWord & SMASK, "secOtp");
        $display("security test done");
        // Clear the divider counter left by the random words first
        acc(1'b1, 1'b0, 8'h02, 32'h0);
        // Divider 3 (ratio 4), delay 2 PLL cycles, ports on
        acc(1'b1, 1'b0, 8'h02, 32'h0008_0700);
        idle(1);
        waitTx(1'b0, c);
        waitTx(1'b1, c);
        c = 0;
        while (txDataLaunch !== 1'b1 && c < 200)
        begin
            step(1);
            c++;
        end
        check("txDelay", c, 8);
        waitTx(1'b1, c);
        waitTx(1'b0, c);
        check("txHigh", c, 8);
        waitTx(1'b1, c);
        check("txLow", c, 8);
        $display("transmit clock test done");
        for (m = 0; m < 2; m++)
        begin
            for (i = 0; i < 4; i++)
            begin
                rd(8'h07 + 8'(i), base[i], "oscBase");
            end
            en = m[0] ? 2'b01 : 2'b10;
            acc(1'b1, 1'b0, 8'h06, {30'h0, en});
            idle(4);
            repeat (3)
            begin
                roscWave = 4'hF;
                step(4);
                roscWave = 4'h0;
                step(4);
            end
            acc(1'b1, 1'b0, 8'h06, 32'h0);
            idle(12);
            for (i = 0; i < 4; i++)
            begin
                base[i][15:0] += (en[i < 2 ? 1 : 0]) ? 16'h0003 : 16'h0000;
                rd(8'h07 + 8'(i), {16'h0, base[i][15:0]}, "osc");
            end
        end
        idle(1);
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        for (i = 0; i < 4; i++)
            rd(8'h07 + 8'(i), {16'h0, base[i][15:0]}, "oscKeep");
        idle(3);
        $display("oscillator test done");
        results();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        $display("watchdog expired");
        results();
    end
endmodule : tb_tile_status_control_regs
`default_nettype wire
